// ### common/pec_pkg.sv
// Package for the performance event counter bank: map, fields, types.
package pec_pkg;
    localparam int NUM_COUNTERS = 8;
    localparam int ADDR_W = 4;
    localparam int EVT_W = 8;
    localparam int EVBUS_W = 16;
    localparam int TAG_WRITE_BIT = 12;

    // Register word offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLR = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_EVENT_TYPE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h5;

    // Field positions.
    localparam int CTRL_GLOBAL_EN_POS = 0;
    localparam int SEL_INDEX_LSB = 0;
    localparam int SEL_INDEX_W = 3;
    localparam int EVT_NUM_LSB = 0;

    // Event numbers and reset values.
    localparam logic [EVT_W-1:0] EVT_TAG_WRITE = 8'h0B;
    localparam logic [EVT_W-1:0] EVT_RESET = 8'h00;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [NUM_COUNTERS-1:0] ENABLE_RESET = 8'h00;
    localparam logic [SEL_INDEX_W-1:0] SELECT_RESET = 3'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pec_bus_req_t;

    // One architecturally executed access to the process tag register.
    typedef struct packed {
        logic valid;
        logic is_write;
    } pec_tag_access_t;
endpackage : pec_pkg

// ### core/pec_counter_bank.sv
// Event counter bank with process-tag-write event and register port.
`timescale 1ns/100ps
// What this block does
// - Mapped event 0x0B advances counter once per executed tag write.
// - Reads of the process tag register never advance counter.
// - Counters 0..7 count only after their enable set bit is written.
// - Selection index chooses the counter that event type reaches.
// - Writing 0x0B to event number maps tag-write onto selected counter.
// - Counting also needs global enable bit in monitor control register.
// - Tag-write event shown on event output bus bit 12, writes only.
module pec_counter_bank (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire pec_pkg::pec_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire pec_pkg::pec_tag_access_t tag_access,
    output logic [pec_pkg::EVBUS_W-1:0] event_output_bus
);
    import pec_pkg::*;

    logic monitor_control_reg;
    logic [NUM_COUNTERS-1:0] counter_enable_set_reg;
    logic [SEL_INDEX_W-1:0] counter_selection_reg;
    logic [EVT_W-1:0] event_type_reg [NUM_COUNTERS];
    logic [31:0] count_reg [NUM_COUNTERS];
    logic tag_write_hit;
    logic [NUM_COUNTERS-1:0] count_step;
    logic [31:0] bus_rdata_next;
    logic wr_control;
    logic wr_enable_set;
    logic wr_enable_clr;
    logic wr_select;
    logic wr_event_type;
    logic wr_count;

    // One decode serves every register, so the map cannot drift apart.
    function automatic logic reg_write(input pec_bus_req_t req,
            input logic [ADDR_W-1:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction : reg_write

    assign wr_control = reg_write(bus_req, OFS_CONTROL);
    assign wr_enable_set = reg_write(bus_req, OFS_ENABLE_SET);
    assign wr_enable_clr = reg_write(bus_req, OFS_ENABLE_CLR);
    assign wr_select = reg_write(bus_req, OFS_SELECT);
    assign wr_event_type = reg_write(bus_req, OFS_EVENT_TYPE);
    assign wr_count = reg_write(bus_req, OFS_COUNT);

    // Only the write flavour qualifies; a read must never count.
    // write-only qualification
    assign tag_write_hit = tag_access.valid && tag_access.is_write;

    always_comb begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            count_step[i] = tag_write_hit && monitor_control_reg
                && counter_enable_set_reg[i]
                && (event_type_reg[i] == EVT_TAG_WRITE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            monitor_control_reg <= 1'b0;
        end else if (wr_control) begin
            monitor_control_reg <= bus_req.wdata[CTRL_GLOBAL_EN_POS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_enable_set_reg <= ENABLE_RESET;
        end else if (wr_enable_set) begin
            counter_enable_set_reg <= counter_enable_set_reg
                | bus_req.wdata[NUM_COUNTERS-1:0];
        end else if (wr_enable_clr) begin
            counter_enable_set_reg <= counter_enable_set_reg
                & ~bus_req.wdata[NUM_COUNTERS-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_selection_reg <= SELECT_RESET;
        end else if (wr_select) begin
            counter_selection_reg <=
                bus_req.wdata[SEL_INDEX_LSB +: SEL_INDEX_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                event_type_reg[i] <= EVT_RESET;
            end
        end else if (wr_event_type) begin
            event_type_reg[counter_selection_reg] <=
                bus_req.wdata[EVT_NUM_LSB +: EVT_W];
        end
    end

    // A software write to the selected count wins over a same-cycle event.
    // increment and wrap
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                count_reg[i] <= COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                if (wr_count
                    && counter_selection_reg == i[SEL_INDEX_W-1:0]) begin
                    count_reg[i] <= bus_req.wdata;
                end else if (count_step[i]) begin
                    count_reg[i] <= count_reg[i] + 32'h0000_0001;
                end
            end
        end
    end

    // The event line does not depend on any enable, only on qualification.
    // event output bit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            event_output_bus <= '0;
        end else begin
            event_output_bus <= '0;
            event_output_bus[TAG_WRITE_BIT] <= tag_write_hit;
        end
    end

    always_comb begin
        bus_rdata_next = 32'h0000_0000;
        case (bus_req.addr)
            OFS_CONTROL: bus_rdata_next[CTRL_GLOBAL_EN_POS] =
                monitor_control_reg;
            OFS_ENABLE_SET, OFS_ENABLE_CLR:
                bus_rdata_next[NUM_COUNTERS-1:0] = counter_enable_set_reg;
            OFS_SELECT: bus_rdata_next[SEL_INDEX_W-1:0] =
                counter_selection_reg;
            OFS_EVENT_TYPE: bus_rdata_next[EVT_W-1:0] =
                event_type_reg[counter_selection_reg];
            OFS_COUNT: bus_rdata_next = count_reg[counter_selection_reg];
            default: bus_rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            bus_rdata <= bus_rdata_next;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    property p_read_no_count;
        @(posedge core_clk) disable iff (sys_rst)
        (tag_access.valid && !tag_access.is_write
            && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> count_reg[0] == $past(count_reg[0]);
    endproperty
    a_read_no_count: assert property (p_read_no_count)
        else $error("Counter 0 moved on a tag read.");

    property p_count_one;
        @(posedge core_clk) disable iff (sys_rst)
        (count_step[0] && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> count_reg[0] == $past(count_reg[0]) + 32'h0000_0001;
    endproperty
    a_count_one: assert property (p_count_one)
        else $error("Counter 0 did not advance by one.");

    property p_need_enables;
        @(posedge core_clk) disable iff (sys_rst)
        (!monitor_control_reg || !counter_enable_set_reg[0])
        && !(bus_req.wr && bus_req.addr == OFS_COUNT)
        |=> $stable(count_reg[0]);
    endproperty
    a_need_enables: assert property (p_need_enables)
        else $error("Counter 0 moved while disabled.");

    property p_event_bit;
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> event_output_bus[TAG_WRITE_BIT]
            == $past(tag_access.valid && tag_access.is_write);
    endproperty
    a_event_bit: assert property (p_event_bit)
        else $error("Event output bit does not follow tag writes.");

    property p_enable_set;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == OFS_ENABLE_SET && bus_req.wdata[0])
        |=> counter_enable_set_reg[0];
    endproperty
    a_enable_set: assert property (p_enable_set)
        else $error("Enable set write did not enable counter 0.");

    property p_select;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == OFS_SELECT)
        |=> counter_selection_reg
            == $past(bus_req.wdata[SEL_INDEX_LSB +: SEL_INDEX_W]);
    endproperty
    a_select: assert property (p_select)
        else $error("Selection index not stored.");

    property p_map;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == OFS_EVENT_TYPE)
        |=> event_type_reg[$past(counter_selection_reg)]
            == $past(bus_req.wdata[EVT_NUM_LSB +: EVT_W]);
    endproperty
    a_map: assert property (p_map)
        else $error("Event number not mapped to selected counter.");

    property p_wrap;
        @(posedge core_clk) disable iff (sys_rst)
        (count_step[0] && count_reg[0] == 32'hFFFF_FFFF
            && !(bus_req.wr && bus_req.addr == OFS_COUNT))
        |=> count_reg[0] == 32'h0000_0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Counter 0 did not wrap to zero.");

    // A read of the tag register must leave the event line quiet.
    property p_read_no_event;
        @(posedge core_clk) disable iff (sys_rst)
        tag_access.valid && !tag_access.is_write
        |=> !event_output_bus[TAG_WRITE_BIT];
    endproperty
    a_read_no_event: assert property (p_read_no_event)
        else $error("Event output bit pulsed on a tag read.");

    property p_other_bits_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        event_output_bus[EVBUS_W-1:TAG_WRITE_BIT+1] == '0
            && event_output_bus[TAG_WRITE_BIT-1:0] == '0;
    endproperty
    a_other_bits_quiet: assert property (p_other_bits_quiet)
        else $error("An unused event output bit is set.");

    property p_type_read;
        @(posedge core_clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == OFS_EVENT_TYPE
        |=> bus_rdata[EVT_W-1:0]
            == event_type_reg[$past(counter_selection_reg)];
    endproperty
    a_type_read: assert property (p_type_read)
        else $error("Event type read did not reach the selected counter.");

    // Every counter is checked, not only counter 0 above.
    for (genvar g = 0; g < NUM_COUNTERS; g++) begin : g_counter_chk
        localparam logic [SEL_INDEX_W-1:0] IDX = SEL_INDEX_W'(g);
        logic own_write;
        assign own_write = wr_count && (counter_selection_reg == IDX);

        property p_idle_hold;
            @(posedge core_clk) disable iff (sys_rst)
            !count_step[g] && !own_write |=> $stable(count_reg[g]);
        endproperty
        a_idle_hold: assert property (p_idle_hold)
            else $error("A counter moved with no event and no write.");

        property p_step_one;
            @(posedge core_clk) disable iff (sys_rst)
            count_step[g] && !own_write
            |=> count_reg[g] == $past(count_reg[g]) + 32'h0000_0001;
        endproperty
        a_step_one: assert property (p_step_one)
            else $error("A counter did not advance by exactly one.");

        property p_own_enable;
            @(posedge core_clk) disable iff (sys_rst)
            !counter_enable_set_reg[g] |-> !count_step[g];
        endproperty
        a_own_enable: assert property (p_own_enable)
            else $error("A counter stepped without its own enable.");

        property p_global_enable;
            @(posedge core_clk) disable iff (sys_rst)
            !monitor_control_reg |-> !count_step[g];
        endproperty
        a_global_enable: assert property (p_global_enable)
            else $error("A counter stepped with the global enable off.");

        property p_read_no_step;
            @(posedge core_clk) disable iff (sys_rst)
            tag_access.valid && !tag_access.is_write |-> !count_step[g];
        endproperty
        a_read_no_step: assert property (p_read_no_step)
            else $error("A counter stepped on a tag read.");

        property p_unmapped_no_step;
            @(posedge core_clk) disable iff (sys_rst)
            event_type_reg[g] != EVT_TAG_WRITE |-> !count_step[g];
        endproperty
        a_unmapped_no_step: assert property (p_unmapped_no_step)
            else $error("A counter stepped on another event number.");

        property p_write_steps;
            @(posedge core_clk) disable iff (sys_rst)
            tag_access.valid && tag_access.is_write && monitor_control_reg
                && counter_enable_set_reg[g]
                && event_type_reg[g] == EVT_TAG_WRITE
            |-> count_step[g];
        endproperty
        a_write_steps: assert property (p_write_steps)
            else $error("A mapped enabled counter missed a tag write.");
    end
endmodule : pec_counter_bank

// ### sim/pec_core_model.sv
// Model of the core pipeline executing process tag register accesses.
`timescale 1ns/100ps
module pec_core_model (
    input wire logic core_clk,
    output pec_pkg::pec_tag_access_t tag_access
);
    import pec_pkg::*;
    initial tag_access = '0;
    // Idle cycles show the opposite kind, so a stale is_write cannot pass.
    task automatic run(input int n, input logic wr);
        repeat (n) begin
            @(posedge core_clk);
            tag_access <= '{valid: 1'b1, is_write: wr};
        end
        if (n > 0) begin
            @(posedge core_clk);
            tag_access <= '{valid: 1'b0, is_write: ~wr};
        end
    endtask : run
endmodule : pec_core_model

// ### sim/pec_counter_bank_test.sv
// Self-checking bench for the event counter bank.
`timescale 1ns/100ps
module pec_counter_bank_test;
    import pec_pkg::*;
    typedef struct packed {
        logic [2:0] idx;
        logic [7:0] nw;
        logic [7:0] nr;
        logic [31:0] cnt;
    } pec_row_t;
    logic core_clk;
    logic sys_rst;
    pec_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    pec_tag_access_t tag_access;
    logic [EVBUS_W-1:0] event_output_bus;
    int failures;
    int check_count;
    int cycles;
    int ev_cnt;
    int ev_base;
    logic stray_bits;
    pec_row_t rows [4];
    pec_counter_bank i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .tag_access(tag_access),
        .event_output_bus(event_output_bus));
    pec_core_model i_core (.core_clk(core_clk), .tag_access(tag_access));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // The whole run needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (event_output_bus[TAG_WRITE_BIT] === 1'b1) ev_cnt <= ev_cnt + 1;
        if (!sys_rst && (event_output_bus & ~(16'h0001 << TAG_WRITE_BIT))
                !== 16'h0000) begin
            stray_bits <= 1'b1;
        end
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
            input logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(what, exp, bus_rdata);
    endtask : rd_chk
    task automatic map(input logic [2:0] idx, input logic [7:0] evt);
        wr_reg(OFS_SELECT, {29'h0000_0000, idx});
        wr_reg(OFS_EVENT_TYPE, {24'h00_0000, evt});
    endtask : map
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        sys_rst = 1'b1;
        bus_req = '0;
        cycles = 0;
        ev_cnt = 0;
        stray_bits = 1'b0;
        failures = 0;
        check_count = 0;
        rows[0] = '{3'h0, 8'h03, 8'h02, 32'h0000_0003};
        rows[1] = '{3'h7, 8'h01, 8'h04, 32'h0000_0001};
        rows[2] = '{3'h3, 8'h00, 8'h03, 32'h0000_0000};
        rows[3] = '{3'h5, 8'h05, 8'h00, 32'h0000_0005};
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_chk("reset read", a[3:0], 32'h0000_0000);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            map(rows[i].idx, EVT_TAG_WRITE);
            wr_reg(OFS_ENABLE_SET, 32'h1 << rows[i].idx);
            wr_reg(OFS_CONTROL, 32'h0000_0001);
            ev_base = ev_cnt;
            i_core.run(rows[i].nw, 1'b1);
            i_core.run(rows[i].nr, 1'b0);
            rd_chk("count", OFS_COUNT, rows[i].cnt);
            chk("pulses", rows[i].nw, ev_cnt - ev_base);
            wr_reg(OFS_ENABLE_CLR, 32'h1 << rows[i].idx);
        end
        $display("test rows done");
        wr_reg(OFS_SELECT, 32'h0000_0000);
        rd_chk("held count", OFS_COUNT, 32'h0000_0003);
        map(3'h2, EVT_TAG_WRITE);
        wr_reg(OFS_ENABLE_SET, 32'h0000_0004);
        wr_reg(OFS_CONTROL, 32'h0000_0000);
        rd_chk("control", OFS_CONTROL, 32'h0000_0000);
        rd_chk("select", OFS_SELECT, 32'h0000_0002);
        rd_chk("enables", OFS_ENABLE_CLR, 32'h0000_0004);
        ev_base = ev_cnt;
        i_core.run(2, 1'b1);
        rd_chk("global off", OFS_COUNT, 32'h0000_0000);
        chk("ungated pulses", 32'h0000_0002, ev_cnt - ev_base);
        $display("test global enable done");
        wr_reg(OFS_CONTROL, 32'h0000_0001);
        wr_reg(OFS_EVENT_TYPE, 32'h0000_000C);
        rd_chk("event type", OFS_EVENT_TYPE, 32'h0000_000C);
        i_core.run(1, 1'b1);
        rd_chk("other event", OFS_COUNT, 32'h0000_0000);
        $display("test event map done");
        wr_reg(OFS_EVENT_TYPE, 32'h0000_000B);
        wr_reg(OFS_COUNT, 32'hFFFF_FFFF);
        i_core.run(1, 1'b1);
        rd_chk("wrap", OFS_COUNT, 32'h0000_0000);
        i_core.run(2, 1'b1);
        rd_chk("after wrap", OFS_COUNT, 32'h0000_0002);
        $display("test wrap done");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk("count after reset", OFS_COUNT, 32'h0000_0000);
        rd_chk("control after reset", OFS_CONTROL, 32'h0000_0000);
        rd_chk("type after reset", OFS_EVENT_TYPE, 32'h0000_0000);
        ev_base = ev_cnt;
        i_core.run(1, 1'b1);
        rd_chk("count stays off", OFS_COUNT, 32'h0000_0000);
        chk("reset pulses", 32'h0000_0001, ev_cnt - ev_base);
        chk("stray bits", 32'h0000_0000, {31'h0, stray_bits});
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : pec_counter_bank_test
